/* File: fpk_flash_ctrl.v */
`timescale 1ns/100ps
`default_nettype none
`include "fpk_consts.vh"
// What this block does
// (RQ1) Programming only clears bits; ones come back only by erase.
// (RQ2) Writes and erases are timed internally; no data polling needed.
// (RQ3) Instruction execution stalls while a write or erase runs.
// (RQ4) Reads always allowed; writes and erases only after key unlock.
// (RQ5) Key register gets 0xa5 then 0xf1 to arm one operation.
// (RQ6) Any delay between key writes; only order matters.
// (RQ7) Wrong or out-of-order key disables writes and erases until reset.
// (RQ8) Write or erase before full key sequence disables until reset.
// (RQ9) Lock re-arms after every write or erase.
// (RQ10) Write enable set sends external-move writes to flash, not data memory.
// (RQ11) Write enable stays set until software clears it.
// (RQ12) 8k byte array in 512-byte pages; page is erase granule.
// (RQ13) Erase sets every byte of the page to 0xff.
// (RQ14) Erase and write enable plus keys: any write erases the whole page.
// (RQ15) Software disables interrupts, sets enables, writes keys, then writes.
// (RQ16) Programming is one byte per operation from debug port or software.
// (RQ17) Debug port can program a blank device without code.
// (RQ18) Software that writes flash should keep the supply monitor on.
// (RQ19) Byte write: keys repeated before every external-move byte write.
// (RQ20) Software clears write enable when flash writes are done.
// (RQ21) Busy shown from one cycle after the request is taken to the end of the operation; durations are clock-count parameters.
// (RQ22) Key write while armed counts as out of sequence.
module fpk_flash_ctrl #(
    // Array geometry: address and page-offset widths
    parameter AW        = `FPK_ADDR_W,
    parameter PW        = `FPK_PAGE_W,
    parameter DEPTH     = `FPK_DEPTH,
    // Durations in system clock cycles; an erase needs at least one page of counts
    parameter WRITE_CYC = `FPK_WRITE_CYC,
    parameter ERASE_CYC = `FPK_ERASE_CYC
) (
    // Clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // Program-store control register write
    input  wire          psc_wr,
    input  wire [7:0]    psc_wdata,
    // Key register write
    input  wire          key_wr,
    input  wire [7:0]    key_wdata,
    // Core external-move write path
    input  wire          xmove_wr,
    input  wire [AW-1:0] xmove_addr,
    input  wire [7:0]    xmove_wdata,
    // Two-wire debug port programming path
    input  wire          dbg_wr,
    input  wire          dbg_erase,
    input  wire [AW-1:0] dbg_addr,
    input  wire [7:0]    dbg_wdata,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output wire [7:0]    rd_data,
    // Data-memory redirect when flash is not targeted
    output reg           xdata_wr,
    output reg  [AW-1:0] xdata_addr,
    output reg  [7:0]    xdata_wdata,
    // Status
    output reg           store_write_enable,
    output reg           store_erase_enable,
    output reg           key_armed,
    output reg           key_locked_out,
    output reg           core_stall,
    output reg           flash_busy
);
    // Sequencer states, one-hot
    // RMW fetches the old byte, WRT programs and times it, ERS fills and times a page
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RMW  = 4'h2;
    localparam [3:0] ST_WRT  = 4'h4;
    localparam [3:0] ST_ERS  = 4'h8;

    // Key sequencer states, one-hot; the lock-out is a flag of its own
    // so that nothing but system reset can leave it
    localparam [2:0] KEY_NONE  = 3'h1;
    localparam [2:0] KEY_FIRST = 3'h2;
    localparam [2:0] KEY_ARMED = 3'h4;

    // Sequencer state, cycle counter and the captured request
    reg [3:0]    state_reg;
    reg [2:0]    key_reg;
    reg [31:0]   cnt_reg;
    reg [AW-1:0] op_addr_reg;
    reg [7:0]    op_data_reg;
    reg [PW-1:0] erase_idx_reg;

    // Array port, steered by the write-strobe process
    reg          op_fin;
    reg          mem_wr;
    reg [AW-1:0] mem_waddr;
    reg [7:0]    mem_wdata;
    wire [7:0]   mem_rdata;
    wire [AW-1:0] mem_raddr;

    // Request decodes
    wire         sw_flash_wr;
    wire         idle;

    // One-hot: bit 0 alone marks the idle state
    assign idle = state_reg[0];
    // External-move writes target flash while write enable is set
    assign sw_flash_wr = xmove_wr & store_write_enable; // [RQ10]
    // Reads are never refused, but while busy the port serves the read-modify-write,
    // so read data mean something only while idle; the core is stalled then anyway
    assign mem_raddr = idle ? rd_addr : op_addr_reg;
    assign rd_data = mem_rdata; // [RQ4]

    // Array with a registered read port; the old byte for a program
    // comes back through the same port one cycle after its address
    fpk_mem #(.AW(AW), .DEPTH(DEPTH)) u_mem (
        .ref_clk (ref_clk),
        .wr_en   (mem_wr),
        .wr_addr (mem_waddr),
        .wr_data (mem_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_rdata)
    );

    // Program-store control bits; only software changes them
    // Both bits are written together; hardware never clears them, so they
    // survive every operation and every lock-out
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            store_write_enable <= 1'b0;
            store_erase_enable <= 1'b0;
        end else if (psc_wr) begin
            store_write_enable <= psc_wdata[`FPK_PSC_WE_BIT]; // [RQ11]
            store_erase_enable <= psc_wdata[`FPK_PSC_EE_BIT];
        end
    end

    // Key sequencer; lock-out is sticky until system reset
    // A key write outranks an external-move write in the same cycle, and the
    // sequencer then drops the move, so one request can never arm and use the keys
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_reg        <= KEY_NONE;
            key_locked_out <= 1'b0;
        end else if (!key_locked_out) begin
            // Once locked out nothing here moves until reset
            if (key_wr) begin
                case (key_reg)
                    KEY_NONE: begin
                        // Only the first code may start a sequence
                        if (key_wdata == `FPK_KEY_FIRST) begin
                            key_reg <= KEY_FIRST; // [RQ5] [RQ6]
                        end else begin
                            key_locked_out <= 1'b1; // [RQ7]
                        end
                    end
                    KEY_FIRST: begin
                        // Only the second code completes it
                        if (key_wdata == `FPK_KEY_SECOND) begin
                            key_reg <= KEY_ARMED; // [RQ5]
                        end else begin
                            key_locked_out <= 1'b1; // [RQ7]
                        end
                    end
                    default: begin
                        // A key while armed breaks the sequence
                        key_locked_out <= 1'b1; // [RQ22]
                        key_reg        <= KEY_NONE;
                    end
                endcase
            end else if (sw_flash_wr && idle) begin
                // An attempt uses up the arming, or locks out if there was none;
                // moves while busy are ignored here as they are by the sequencer
                if (key_reg == KEY_ARMED) begin
                    key_reg <= KEY_NONE; // [RQ9]
                end else begin
                    key_locked_out <= 1'b1; // [RQ8]
                    key_reg        <= KEY_NONE;
                end
            end
        end
    end

    // Data-memory redirect, registered
    // Address and data are captured every cycle; only the strobe marks a real
    // write, which keeps the path free of enables on the wide fields
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xdata_wr    <= 1'b0;
            xdata_addr  <= {AW{1'b0}};
            xdata_wdata <= 8'h00;
        end else begin
            xdata_wr    <= xmove_wr & ~store_write_enable; // [RQ10]
            xdata_addr  <= xmove_addr;
            xdata_wdata <= xmove_wdata;
        end
    end

    // Operation sequencer: one byte or one page per operation
    // Requests that arrive while not idle are dropped: the stall keeps the core
    // from issuing them, and the debug host must wait for busy to fall.
    // Trade-off: no request queue, at the cost of that rule on both requesters
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 32'h0;
            op_addr_reg   <= {AW{1'b0}};
            op_data_reg   <= 8'h00;
            erase_idx_reg <= {PW{1'b0}};
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // Counters start from zero for every operation
                    cnt_reg       <= 32'h0;
                    erase_idx_reg <= {PW{1'b0}};
                    // Debug port outranks software and needs no keys
                    if (dbg_erase) begin
                        op_addr_reg <= dbg_addr;
                        state_reg   <= ST_ERS; // [RQ17]
                    end else if (dbg_wr) begin
                        op_addr_reg <= dbg_addr;
                        op_data_reg <= dbg_wdata;
                        state_reg   <= ST_RMW; // [RQ16] [RQ17]
                    end else if (sw_flash_wr && !key_wr && !key_locked_out
                                 && key_reg == KEY_ARMED) begin // [RQ4]
                        op_addr_reg <= xmove_addr;
                        op_data_reg <= xmove_wdata;
                        // Erase enable picks a page erase, otherwise one byte
                        if (store_erase_enable) begin
                            state_reg <= ST_ERS; // [RQ14]
                        end else begin
                            state_reg <= ST_RMW; // [RQ16]
                        end
                    end
                end
                ST_RMW: begin
                    // Wait one cycle for the old byte to be read
                    state_reg <= ST_WRT;
                end
                ST_WRT: begin
                    // The array is written on count zero; the rest only times the cell
                    cnt_reg <= cnt_reg + 32'h1;
                    if (cnt_reg >= WRITE_CYC - 1) begin
                        state_reg <= ST_IDLE; // [RQ2]
                    end
                end
                ST_ERS: begin
                    // The page fill takes the first 512 counts; a shorter ERASE_CYC
                    // would leave the top of the page as it was
                    cnt_reg <= cnt_reg + 32'h1;
                    if (erase_idx_reg != {PW{1'b1}}) begin
                        erase_idx_reg <= erase_idx_reg + {{(PW-1){1'b0}}, 1'b1};
                    end
                    if (cnt_reg >= ERASE_CYC - 1) begin
                        state_reg <= ST_IDLE; // [RQ2]
                    end
                end
                default: begin
                    // An illegal code falls back to idle
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Array write strobes: program ANDs, erase fills the page
    // The old byte stands on the read port during count zero, so the AND can
    // only clear bits; turning a zero back to one needs an erase first
    always @* begin
        mem_wr    = 1'b0;
        mem_waddr = op_addr_reg;
        mem_wdata = op_data_reg & mem_rdata; // [RQ1]
        op_fin    = 1'b0;
        // Byte program strobe, one write per operation
        if (state_reg == ST_WRT && cnt_reg == 32'h0) begin
            mem_wr = 1'b1;
        end
        // Page fill, one byte per cycle
        if (state_reg == ST_ERS && cnt_reg < (32'h1 << PW)) begin
            mem_wr    = 1'b1;
            mem_waddr = {op_addr_reg[AW-1:PW], erase_idx_reg}; // [RQ12]
            mem_wdata = `FPK_ERASED_BYTE; // [RQ13]
        end
        // Finish marks the last counted cycle of either operation
        if ((state_reg == ST_WRT && cnt_reg >= WRITE_CYC - 1)
            || (state_reg == ST_ERS && cnt_reg >= ERASE_CYC - 1)) begin
            op_fin = 1'b1;
        end
    end

    // Status outputs, registered
    // Busy and stall rise one cycle after the request is taken, so a requester
    // must leave one idle cycle before its next request
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_armed  <= 1'b0;
            flash_busy <= 1'b0;
            core_stall <= 1'b0;
        end else begin
            // Arming shows one cycle after the second code lands
            key_armed  <= (key_reg == KEY_ARMED) & ~key_locked_out;
            flash_busy <= ~idle & ~op_fin; // [RQ21]
            core_stall <= ~idle & ~op_fin; // [RQ3]
        end
    end
endmodule // fpk_flash_ctrl
`default_nettype wire

/* File: fpk_consts.vh */
`ifndef FPK_CONSTS_VH
`define FPK_CONSTS_VH
// Key codes
`define FPK_KEY_FIRST      8'ha5
`define FPK_KEY_SECOND     8'hf1
// Erased byte value
`define FPK_ERASED_BYTE    8'hff
// Program-store control bit positions
`define FPK_PSC_WE_BIT     0
`define FPK_PSC_EE_BIT     1
// Array geometry: 8k bytes in 512-byte pages
`define FPK_ADDR_W         13
`define FPK_PAGE_W         9
`define FPK_DEPTH          8192
// Operation times at their typical values
`define FPK_WRITE_NS       55000
`define FPK_ERASE_NS       15000000
`define FPK_CLK_NS         4
`define FPK_WRITE_CYC      (`FPK_WRITE_NS / `FPK_CLK_NS)
`define FPK_ERASE_CYC      (`FPK_ERASE_NS / `FPK_CLK_NS)
`endif

/* File: fpk_mem.v */
`timescale 1ns/100ps
`default_nettype none
// Byte-wide flash array; read data comes from a register
module fpk_mem #(
    parameter AW = 13,
    parameter DEPTH = 8192
) (
    // Clock
    input  wire          ref_clk,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]    wr_data,
    // Read port
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data
);
    reg [7:0] mem_reg [0:DEPTH-1];

    // Single write and registered read
    always @(posedge ref_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data <= mem_reg[rd_addr];
    end
endmodule // fpk_mem
`default_nettype wire

/* File: fpk_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module fpk_chk #(
    parameter WRITE_CYC = 20
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Requests
    input wire logic        psc_wr,
    input wire logic        key_wr,
    input wire logic [7:0]  key_wdata,
    input wire logic        xmove_wr,
    input wire logic [12:0] xmove_addr,
    input wire logic [7:0]  xmove_wdata,
    // Outputs
    input wire logic        xdata_wr,
    input wire logic [12:0] xdata_addr,
    input wire logic [7:0]  xdata_wdata,
    input wire logic        store_write_enable,
    input wire logic        key_armed,
    input wire logic        key_locked_out,
    input wire logic        core_stall,
    input wire logic        flash_busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] busy_cnt;
    // A flash write the block is bound to take
    wire go = xmove_wr && store_write_enable && !flash_busy && !key_wr && !psc_wr;
    // Busy length, so a short timed operation cannot slip by
    always @(posedge ref_clk or posedge rst) begin
        if (rst) busy_cnt <= 32'h0;
        else busy_cnt <= flash_busy ? busy_cnt + 32'h1 : 32'h0;
    end
    a_lock_sticky: assert property (key_locked_out |=> key_locked_out) else $error("lock fell");
    a_bad_key: assert property (key_wr && key_wdata != 8'ha5 && key_wdata != 8'hf1
        |=> key_locked_out) else $error("wrong key kept");
    a_armed_key: assert property (key_armed && key_wr |=> key_locked_out) else $error("rekey");
    a_unarmed_op: assert property (go && !key_armed |=> key_locked_out) else $error("no lock");
    a_op_start: assert property (go && key_armed |=> ##[0:1] flash_busy) else $error("no op");
    a_op_relock: assert property ($rose(flash_busy) |-> !key_armed) else $error("armed");
    a_stall_busy: assert property (core_stall == flash_busy) else $error("stall");
    a_busy_len: assert property ($fell(flash_busy) |-> busy_cnt >= WRITE_CYC) else $error("short");
    a_data_path: assert property (xmove_wr && !store_write_enable && !psc_wr && !flash_busy
        |=> xdata_wr && xdata_addr == $past(xmove_addr) && xdata_wdata == $past(xmove_wdata))
        else $error("redirect");
    a_we_hold: assert property (!psc_wr |=> $stable(store_write_enable)) else $error("we");
endmodule // fpk_chk
`default_nettype wire

/* File: fpk_core.sv */
`timescale 1ns/100ps
`default_nettype none
module fpk_core (
    // Clock and stall
    input  wire logic        ref_clk,
    input  wire logic        core_stall,
    // Register writes
    output var logic        psc_wr,
    output var logic [7:0]  psc_wdata,
    output var logic        key_wr,
    output var logic [7:0]  key_wdata,
    // External-move write
    output var logic        xmove_wr,
    output var logic [12:0] xmove_addr,
    output var logic [7:0]  xmove_wdata
);
    // Quiet bus at time zero
    initial begin
        {psc_wr, key_wr, xmove_wr} = 3'b000;
        {psc_wdata, key_wdata, xmove_wdata, xmove_addr} = 37'h0;
    end
    // One-cycle request: k 0 control, 1 key, 2 external move
    task automatic req(input [1:0] k, input [12:0] a, input [7:0] d);
        @(negedge ref_clk);
        while (core_stall) @(negedge ref_clk);
        {psc_wdata, key_wdata, xmove_wdata} = {3{d}};
        xmove_addr = a;
        {psc_wr, key_wr, xmove_wr} = 3'b100 >> k;
        @(negedge ref_clk);
        {psc_wr, key_wr, xmove_wr} = 3'b000;
        // Released lines show the inverse so stale values cannot pass
        {psc_wdata, key_wdata, xmove_wdata} = ~{3{d}};
        xmove_addr = ~a;
    endtask
    // Both codes in order ahead of every operation
    task automatic keys;
        req(2'd1, 13'h0, 8'ha5);
        req(2'd1, 13'h0, 8'hf1);
    endtask
endmodule // fpk_core
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam WC = 20;
    localparam EC = 600;
    logic        ref_clk, rst, psc_wr, key_wr, xmove_wr, dbg_wr, dbg_erase, xdata_wr;
    logic        store_write_enable, store_erase_enable, key_armed, key_locked_out;
    logic        core_stall, flash_busy;
    logic [7:0]  psc_wdata, key_wdata, xmove_wdata, dbg_wdata, rd_data, xdata_wdata;
    logic [12:0] xmove_addr, dbg_addr, rd_addr, xdata_addr;
    integer      mismatches, comparisons, n;
    fpk_flash_ctrl #(.WRITE_CYC(WC), .ERASE_CYC(EC)) u_dut (.ref_clk, .rst, .psc_wr,
        .psc_wdata, .key_wr, .key_wdata, .xmove_wr, .xmove_addr, .xmove_wdata, .dbg_wr,
        .dbg_erase, .dbg_addr, .dbg_wdata, .rd_addr, .rd_data, .xdata_wr, .xdata_addr,
        .xdata_wdata, .store_write_enable, .store_erase_enable, .key_armed,
        .key_locked_out, .core_stall, .flash_busy);
    fpk_core u_core (.ref_clk, .core_stall, .psc_wr, .psc_wdata, .key_wr, .key_wdata,
        .xmove_wr, .xmove_addr, .xmove_wdata);
    // Free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Counts busy cycles; bounded so a stuck operation cannot hang
    task automatic wait_idle(output integer c);
        integer i;
        c = 0;
        for (i = 0; i < 3 || (flash_busy === 1'b1 && i < 2000); i = i + 1) begin
            c = c + (flash_busy === 1'b1);
            @(negedge ref_clk);
        end
    endtask
    task automatic rd(input [12:0] a, input [7:0] e);
        @(negedge ref_clk);
        rd_addr = a;
        repeat (2) @(negedge ref_clk);
        chk(rd_data, e);
    endtask
    // Debug port byte program, or page erase when e is set
    task automatic dbg(input e, input [12:0] a, input [7:0] d);
        @(negedge ref_clk);
        {dbg_erase, dbg_wr, dbg_addr, dbg_wdata} = {e, !e, a, d};
        @(negedge ref_clk);
        {dbg_erase, dbg_wr} = 2'b00;
        dbg_wdata = ~d;
        wait_idle(n);
    endtask
    // rst stands for the supply monitor's reset, which is kept enabled
    task automatic do_reset;
        rst = 1'b1;
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
    endtask
    task automatic t_dbg;
        integer p;
        for (p = 0; p < 3; p = p + 1) dbg(1'b1, 13'(p * 512), 8'h0);
        chk(n >= WC, 1);
        dbg(1'b0, 13'h1ff, 8'h0);
        dbg(1'b0, 13'h400, 8'h3c);
        rd(13'h1ff, 8'h0);
        rd(13'h400, 8'h3c);
        rd(13'h3ff, 8'hff);
        $display("t_dbg done");
    endtask
    task automatic t_erase;
        u_core.req(2'd2, 13'h123, 8'h5a);
        chk({xdata_wr, xdata_addr, xdata_wdata}, {1'b1, 13'h123, 8'h5a});
        // Put a zero into the page first so the erase has something to undo
        dbg(1'b0, 13'h200, 8'h00);
        u_core.req(2'd0, 13'h0, 8'h03);
        u_core.keys;
        u_core.req(2'd2, 13'h2a5, 8'h55);
        @(negedge ref_clk);
        chk(core_stall, 1);
        wait_idle(n);
        rd(13'h1ff, 8'h0);
        rd(13'h200, 8'hff);
        rd(13'h3ff, 8'hff);
        chk(store_write_enable, 1);
        chk(store_erase_enable, 1);
        $display("t_erase done");
    endtask
    task automatic t_prog;
        u_core.req(2'd0, 13'h0, 8'h01);
        u_core.req(2'd1, 13'h0, 8'ha5);
        repeat (50) @(negedge ref_clk);
        u_core.req(2'd1, 13'h0, 8'hf1);
        @(negedge ref_clk);
        chk(key_armed, 1);
        u_core.req(2'd2, 13'h400, 8'h0f);
        wait_idle(n);
        chk(n >= WC, 1);
        chk(key_armed, 0);
        rd(13'h400, 8'h0c);
        u_core.req(2'd2, 13'h401, 8'h00);
        chk(key_locked_out, 1);
        rd(13'h400, 8'h0c);
        rd(13'h401, 8'hff);
        u_core.req(2'd0, 13'h0, 8'h00);
        chk(store_write_enable, 0);
        u_core.req(2'd2, 13'h402, 8'h77);
        chk({xdata_wr, xdata_addr, xdata_wdata}, {1'b1, 13'h402, 8'h77});
        $display("t_prog done");
    endtask
    // Wrong code, out of order, and a key while armed
    task automatic t_badkeys;
        logic [23:0] s [3];
        integer      j, k;
        s = '{24'ha5f1a5, 24'hf1, 24'h5a};
        for (j = 0; j < 3; j = j + 1) begin
            do_reset;
            u_core.req(2'd0, 13'h0, 8'h01);
            for (k = (j == 0) ? 2 : 0; k >= 0; k = k - 1) u_core.req(2'd1, 13'h0, s[j][k*8 +: 8]);
            chk(key_locked_out, 1);
            u_core.keys;
            u_core.req(2'd2, 13'h401, 8'h00);
            wait_idle(n);
            chk(n, 0);
        end
        $display("t_badkeys done");
    endtask
    // Watchdog sized well past the expected run
    initial begin
        #200000;
        mismatches = mismatches + 1;
        end_sim;
    end
    // Main sequence
    initial begin
        mismatches = 0;
        comparisons = 0;
        {dbg_wr, dbg_erase, dbg_addr, dbg_wdata, rd_addr} = 36'h0;
        do_reset;
        chk({xdata_wr, store_write_enable, key_armed, key_locked_out, flash_busy}, 0);
        t_dbg;
        t_erase;
        t_prog;
        t_badkeys;
        end_sim;
    end
endmodule // tb_top
bind fpk_flash_ctrl fpk_chk #(.WRITE_CYC(WRITE_CYC)) u_chk (.ref_clk, .rst, .psc_wr, .key_wr,
    .key_wdata, .xmove_wr, .xmove_addr, .xmove_wdata, .xdata_wr, .xdata_addr, .xdata_wdata,
    .store_write_enable, .key_armed, .key_locked_out, .core_stall, .flash_busy);
`default_nettype wire
